// ---- rtl/plddec_top.sv ----
// decode array, general logic array, cell registers and configuration registers
`timescale 1ns/1ps

module plddec_top #(
	parameter plddec_pkg::plddec_dec_tab_t DEC_TRUE  = plddec_pkg::plddec_dec_true_def(),
	parameter plddec_pkg::plddec_dec_tab_t DEC_FALSE = '0,
	parameter logic [plddec_pkg::DEC_TERMS-1:0] DEC_USED = plddec_pkg::DEC_USED_DEF,
	parameter plddec_pkg::plddec_gen_tab_t GEN_TRUE  = '0,
	parameter plddec_pkg::plddec_gen_tab_t GEN_FALSE = '0,
	parameter logic [plddec_pkg::GEN_TERMS-1:0] GEN_USED = '0
) (
	input  wire logic        CLK,
	input  wire logic        NRST,
	input  wire logic [19:0] ADDR,
	input  wire logic        WIDE_ADDR_MODE,
	input  wire logic [2:0]  BUS_CNTL_N,
	input  wire logic [7:0]  DATA_IN,
	output logic [7:0]       DATA_OUT,
	output logic             DATA_OE,
	input  wire logic        POWER_DOWN_IN,
	input  wire logic [7:0]  PORT_A_IN,
	input  wire logic [7:0]  PORT_B_IN,
	input  wire logic [7:0]  PORT_C_IN,
	input  wire logic [3:0]  PORT_D_IN,
	input  wire logic [7:0]  PORT_F_IN,
	input  wire logic        SEC_FLASH_READY,
	output logic [7:0]       PRIMARY_SECTOR_SEL,
	output logic [3:0]       SECONDARY_SECTOR_SEL,
	output logic             SRAM_SEL,
	output logic             CONFIG_BLOCK_SEL,
	output logic             JTAG_PORT_SEL,
	output logic [1:0]       PERIPH_SEL,
	output logic [2:0]       EXT_CHIP_SEL,
	output logic [7:0]       CELL_A_OUT,
	output logic [7:0]       CELL_B_OUT,
	output logic [7:0]       PAGE_OUT,
	output logic             STANDBY
);
	import plddec_pkg::*;

	plddec_state_t          state_r;
	plddec_state_t          state_nxt;
	logic [BUS_W-1:0]       in_bus;
	logic [15:0]            addr_sel;
	logic [2:0]             cntl_gated;
	logic [DEC_TERMS-1:0]   dec_term;
	logic [GEN_TERMS-1:0]   gen_term;
	logic [7:0]             pri_raw;
	logic [3:0]             sec_raw;
	logic                   sram_raw;
	logic                   io_hit;
	logic                   sec_hit;
	logic [CELLS-1:0]       cell_q;
	logic [CELLS-1:0]       cell_d;
	logic [CELLS-1:0]       cell_set;
	logic [CELLS-1:0]       cell_clr;
	logic [CELLS-1:0]       host_mask;
	logic                   wr_end;
	logic                   rd_act;
	logic                   clk_rise;
	logic                   fast_mode;

	// ************************************************************
	// input bus assembly
	// ************************************************************
	assign addr_sel = WIDE_ADDR_MODE ? ADDR[19:WIDE_SHIFT] : ADDR[15:0];
	// a blocked control looks permanently inactive (high) to the arrays
	assign cntl_gated = BUS_CNTL_N | state_r.pmr2[2:0];
	assign cell_q = {state_r.cell_b, state_r.cell_a};

	always_comb begin
		in_bus = '0;
		in_bus[BP_ADDR +: 16] = addr_sel;
		in_bus[BP_CNTL +: 3]  = cntl_gated;
		in_bus[BP_RST]        = ~NRST;
		in_bus[BP_PDN]        = POWER_DOWN_IN;
		in_bus[BP_PA +: 8]    = PORT_A_IN;
		in_bus[BP_PB +: 8]    = PORT_B_IN;
		in_bus[BP_PC +: 8]    = PORT_C_IN;
		in_bus[BP_PD +: 4]    = PORT_D_IN;
		in_bus[BP_PF +: 8]    = PORT_F_IN;
		in_bus[BP_PAGE +: 8]  = state_r.page;
		in_bus[BP_FBA +: 8]   = state_r.cell_a;
		in_bus[BP_FBB +: 8]   = state_r.cell_b;
		in_bus[BP_RDY]        = SEC_FLASH_READY;
	end

	// ************************************************************
	// term arrays, fixed at elaboration
	// ************************************************************
	plddec_and_array #(
		.N          (DEC_TERMS),
		.TRUE_MASK  (DEC_TRUE),
		.FALSE_MASK (DEC_FALSE),
		.USED       (DEC_USED)
	) u_decode_logic_array (
		.in_bus (in_bus),
		.term   (dec_term)
	);

	plddec_and_array #(
		.N          (GEN_TERMS),
		.TRUE_MASK  (GEN_TRUE),
		.FALSE_MASK (GEN_FALSE),
		.USED       (GEN_USED)
	) u_general_logic_array (
		.in_bus (in_bus),
		.term   (gen_term)
	);

	// ************************************************************
	// decode selects
	// ************************************************************
	genvar s;
	generate
		for (s = 0; s < 8; s++) begin : g_pri
			assign pri_raw[s] = |dec_term[DT_PRI + s*SEL_TERMS +: SEL_TERMS];
		end
		for (s = 0; s < 4; s++) begin : g_sec
			assign sec_raw[s] = |dec_term[DT_SEC + s*SEL_TERMS +: SEL_TERMS];
		end
	endgenerate

	assign sram_raw = |dec_term[DT_SRAM +: SEL_TERMS];
	assign io_hit   = sram_raw | dec_term[DT_CFG] | (|dec_term[DT_PERIPH +: 2]);
	assign sec_hit  = |sec_raw;

	// selects stay combinational so decode adds no clock latency
	assign PRIMARY_SECTOR_SEL   = (io_hit | sec_hit) ? 8'h00 : pri_raw;
	assign SECONDARY_SECTOR_SEL = io_hit ? 4'h0 : sec_raw;
	assign SRAM_SEL             = sram_raw;
	assign CONFIG_BLOCK_SEL     = dec_term[DT_CFG];
	assign JTAG_PORT_SEL        = dec_term[DT_JTAG];
	assign PERIPH_SEL           = dec_term[DT_PERIPH +: 2];
	assign EXT_CHIP_SEL         = gen_term[GT_ECS +: 3];

	// ************************************************************
	// output cell logic
	// ************************************************************
	genvar c;
	generate
		for (c = 0; c < CELLS; c++) begin : g_cell
			assign cell_d[c]   = |gen_term[c*CELL_STRIDE + CT_SUM +: SUM_TERMS];
			assign cell_set[c] = gen_term[c*CELL_STRIDE + CT_PRESET];
			assign cell_clr[c] = |gen_term[c*CELL_STRIDE + CT_CLEAR +: 2];
		end
	endgenerate

	assign host_mask = {state_r.mask_b, state_r.mask_a};
	assign clk_rise  = PORT_D_IN[PD_CLKIN] & ~state_r.clkin_prev;
	assign wr_end    = BUS_CNTL_N[CN_WR] & ~state_r.wr_n_prev & dec_term[DT_CFG];
	assign rd_act    = ~BUS_CNTL_N[CN_RD] & dec_term[DT_CFG];
	assign fast_mode = state_r.pmr0[PMR0_FAST_BIT];

	// ************************************************************
	// next state
	// ************************************************************
	always_comb begin
		logic [CELLS-1:0] cells;
		logic [CELLS-1:0] load;
		logic [15:0]      wdata;
		cells = '0;
		load  = '0;
		wdata = '0;
		state_nxt = state_r;
		state_nxt.wr_n_prev  = BUS_CNTL_N[CN_WR];
		state_nxt.clkin_prev = PORT_D_IN[PD_CLKIN];

		// internal cell behaviour: preset, then clear, then clocked data
		for (int i = 0; i < CELLS; i++) begin
			if (cell_set[i]) begin
				cells[i] = 1'b1;
			end else if (cell_clr[i]) begin
				cells[i] = 1'b0;
			end else if (clk_rise) begin
				cells[i] = cell_d[i];
			end else begin
				cells[i] = cell_q[i];
			end
		end

		// host writes at the end of the write strobe
		if (wr_end) begin
			case (ADDR[7:0])
				OFS_CELL_A: begin
					load[7:0]  = ~state_r.mask_a;
					wdata[7:0] = DATA_IN;
				end
				OFS_CELL_B: begin
					load[15:8]  = ~state_r.mask_b;
					wdata[15:8] = DATA_IN;
				end
				OFS_MASK_A: state_nxt.mask_a = DATA_IN;
				OFS_MASK_B: state_nxt.mask_b = DATA_IN;
				OFS_PMR0:   state_nxt.pmr0 = DATA_IN;
				OFS_PMR2:   state_nxt.pmr2 = DATA_IN[PMR2_BITS-1:0];
				OFS_PAGE:   state_nxt.page = DATA_IN;
				default:    state_nxt.page = state_r.page;
			endcase
		end
		// host load beats preset, clear and clock of every unmasked cell of the written group
		cells = (cells & ~load) | (wdata & load);
		state_nxt.cell_a = cells[7:0];
		state_nxt.cell_b = cells[15:8];

		// standby detection on a quiet input bus
		state_nxt.bus_prev = in_bus;
		if (in_bus != state_r.bus_prev) begin
			state_nxt.idle_cnt = '0;
		end else if (state_r.idle_cnt < IDLE_LIMIT) begin
			state_nxt.idle_cnt = state_r.idle_cnt + 1'b1;
		end
		state_nxt.standby = ~fast_mode & (in_bus == state_r.bus_prev) &
			(state_r.idle_cnt >= IDLE_LIMIT - 1'b1);

		// host reads of the configuration block
		state_nxt.rd_oe = rd_act;
		state_nxt.rdata = 8'h00;
		if (rd_act) begin
			case (ADDR[7:0])
				OFS_INCELL_A: state_nxt.rdata = PORT_A_IN;
				OFS_INCELL_B: state_nxt.rdata = PORT_B_IN;
				OFS_INCELL_C: state_nxt.rdata = PORT_C_IN;
				OFS_CELL_A:   state_nxt.rdata = state_r.cell_a;
				OFS_CELL_B:   state_nxt.rdata = state_r.cell_b;
				OFS_MASK_A:   state_nxt.rdata = state_r.mask_a;
				OFS_MASK_B:   state_nxt.rdata = state_r.mask_b;
				OFS_PMR0:     state_nxt.rdata = state_r.pmr0;
				OFS_PMR2:     state_nxt.rdata = {{(8-PMR2_BITS){1'b0}}, state_r.pmr2};
				OFS_PAGE:     state_nxt.rdata = state_r.page;
				OFS_ID0:      state_nxt.rdata = ID0_VALUE;
				OFS_ID1:      state_nxt.rdata = ID1_VALUE;
				default:      state_nxt.rdata = 8'h00;
			endcase
		end
	end

	// ************************************************************
	// state register
	// ************************************************************
	always_ff @(posedge CLK) begin
		if (!NRST) begin
			state_r <= STATE_RST;
		end else begin
			state_r <= state_nxt;
		end
	end

	// ************************************************************
	// registered outputs
	// ************************************************************
	assign DATA_OUT   = state_r.rdata;
	assign DATA_OE    = state_r.rd_oe;
	assign CELL_A_OUT = state_r.cell_a;
	assign CELL_B_OUT = state_r.cell_b;
	assign PAGE_OUT   = state_r.page;
	assign STANDBY    = state_r.standby;

endmodule

// ---- rtl/plddec_pkg.sv ----
// constants, field layouts, term tables and state type of the programmable logic section
package plddec_pkg;

	// ************************************************************
	// input bus layout
	// ************************************************************
	localparam int BUS_W      = 82;
	localparam int BP_ADDR    = 0;
	localparam int BP_CNTL    = 16;
	localparam int BP_RST     = 19;
	localparam int BP_PDN     = 20;
	localparam int BP_PA      = 21;
	localparam int BP_PB      = 29;
	localparam int BP_PC      = 37;
	localparam int BP_PD      = 45;
	localparam int BP_PF      = 49;
	localparam int BP_PAGE    = 57;
	localparam int BP_FBA     = 65;
	localparam int BP_FBB     = 73;
	localparam int BP_RDY     = 81;
	localparam int WIDE_SHIFT = 4;

	// ************************************************************
	// host bus controls (active low), port d clock pin
	// ************************************************************
	localparam int CN_WR      = 0;
	localparam int CN_RD      = 1;
	localparam int CN_PSEN    = 2;
	localparam int PD_CLKIN   = 1;

	// ************************************************************
	// register offsets inside the configuration block
	// ************************************************************
	localparam logic [7:0] OFS_INCELL_A = 8'h18;
	localparam logic [7:0] OFS_INCELL_B = 8'h19;
	localparam logic [7:0] OFS_INCELL_C = 8'h1A;
	localparam logic [7:0] OFS_CELL_A   = 8'h20;
	localparam logic [7:0] OFS_CELL_B   = 8'h21;
	localparam logic [7:0] OFS_MASK_A   = 8'h22;
	localparam logic [7:0] OFS_MASK_B   = 8'h23;
	localparam logic [7:0] OFS_PMR0     = 8'hB0;
	localparam logic [7:0] OFS_PMR2     = 8'hB4;
	localparam logic [7:0] OFS_PAGE     = 8'hE0;
	localparam logic [7:0] OFS_ID0      = 8'hF0;
	localparam logic [7:0] OFS_ID1      = 8'hF1;

	// ************************************************************
	// fields and values after reset
	// ************************************************************
	localparam int         PMR0_FAST_BIT = 3;
	localparam int         PMR2_BITS     = 5;
	localparam logic [7:0] MASK_RST      = 8'h00;
	localparam logic [7:0] PMR0_RST      = 8'h00;
	localparam logic [7:0] PMR2_RST      = 8'h00;
	localparam logic [7:0] PAGE_RST      = 8'h00;
	// identification contents: arbitrary values
	localparam logic [7:0] ID0_VALUE     = 8'h5A;
	localparam logic [7:0] ID1_VALUE     = 8'hA5;

	// ************************************************************
	// standby timing
	// ************************************************************
	localparam int         CLK_PERIOD_NS = 10;
	localparam int         IDLE_NS       = 70;
	localparam int         IDLE_CYCLES   = (IDLE_NS / CLK_PERIOD_NS < 1) ? 1 :
		IDLE_NS / CLK_PERIOD_NS;
	localparam int         IDLE_CNT_W    = 4;
	localparam logic [IDLE_CNT_W-1:0] IDLE_LIMIT = IDLE_CNT_W'(IDLE_CYCLES);

	// ************************************************************
	// product term indices
	// ************************************************************
	localparam int DT_PRI    = 0;
	localparam int DT_SEC    = 24;
	localparam int DT_SRAM   = 36;
	localparam int DT_CFG    = 39;
	localparam int DT_JTAG   = 40;
	localparam int DT_PERIPH = 41;
	localparam int DEC_TERMS = 43;
	localparam int SEL_TERMS = 3;
	localparam int CELLS     = 16;
	localparam int CELL_STRIDE = 8;
	localparam int CT_SUM    = 0;
	localparam int SUM_TERMS = 5;
	localparam int CT_PRESET = 5;
	localparam int CT_CLEAR  = 6;
	localparam int GT_ECS    = 128;
	localparam int GEN_TERMS = 131;

	// default map: configuration block at addresses FF00h..FFFFh, at FF000h..FFFFFh in wide address mode
	localparam logic [BUS_W-1:0] CFG_ADDR_MATCH = 82'hFF00;

	typedef logic [DEC_TERMS-1:0][BUS_W-1:0] plddec_dec_tab_t;
	typedef logic [GEN_TERMS-1:0][BUS_W-1:0] plddec_gen_tab_t;

	function automatic plddec_dec_tab_t plddec_dec_true_def();
		plddec_dec_tab_t t;
		t = '0;
		t[DT_CFG] = CFG_ADDR_MATCH;
		return t;
	endfunction

	localparam logic [DEC_TERMS-1:0] DEC_USED_DEF =
		{{(DEC_TERMS-1-DT_CFG){1'b0}}, 1'b1, {DT_CFG{1'b0}}};

	// ************************************************************
	// complete state of the top module
	// ************************************************************
	typedef struct packed {
		logic [7:0]            cell_a;
		logic [7:0]            cell_b;
		logic [7:0]            mask_a;
		logic [7:0]            mask_b;
		logic [7:0]            pmr0;
		logic [PMR2_BITS-1:0]  pmr2;
		logic [7:0]            page;
		logic [BUS_W-1:0]      bus_prev;
		logic [IDLE_CNT_W-1:0] idle_cnt;
		logic                  standby;
		logic                  wr_n_prev;
		logic                  clkin_prev;
		logic [7:0]            rdata;
		logic                  rd_oe;
	} plddec_state_t;

	localparam plddec_state_t STATE_RST = '{
		mask_a: MASK_RST, mask_b: MASK_RST, pmr0: PMR0_RST,
		pmr2: PMR2_RST[PMR2_BITS-1:0], page: PAGE_RST,
		wr_n_prev: 1'b1, default: '0};

endpackage

// ---- rtl/plddec_and_array.sv ----
// product-term and array: each term ands chosen true and inverted inputs
`timescale 1ns/1ps
module plddec_and_array #(
	parameter int                                   N          = 1,
	parameter logic [N-1:0][plddec_pkg::BUS_W-1:0]  TRUE_MASK  = '0,
	parameter logic [N-1:0][plddec_pkg::BUS_W-1:0]  FALSE_MASK = '0,
	parameter logic [N-1:0]                         USED       = '0
) (
	input  wire logic [plddec_pkg::BUS_W-1:0] in_bus,
	output logic [N-1:0]                      term
);
	import plddec_pkg::*;

	// ************************************************************
	// terms
	// ************************************************************
	genvar i;
	generate
		for (i = 0; i < N; i++) begin : g_term
			// an unused term is held false so it never selects anything
			assign term[i] = USED[i] &
				((in_bus & TRUE_MASK[i]) == TRUE_MASK[i]) &
				((~in_bus & FALSE_MASK[i]) == FALSE_MASK[i]);
		end
	endgenerate

endmodule

// ---- bench/plddec_top_props.sv ----
// port-level assertions for the programmable logic section
`timescale 1ns/1ps
module plddec_top_props (
	input wire logic        CLK,
	input wire logic        NRST,
	input wire logic [19:0] ADDR,
	input wire logic        WIDE_ADDR_MODE,
	input wire logic [2:0]  BUS_CNTL_N,
	input wire logic [7:0]  DATA_IN,
	input wire logic [7:0]  DATA_OUT,
	input wire logic        DATA_OE,
	input wire logic [7:0]  PRIMARY_SECTOR_SEL,
	input wire logic [3:0]  SECONDARY_SECTOR_SEL,
	input wire logic        SRAM_SEL,
	input wire logic        CONFIG_BLOCK_SEL,
	input wire logic [1:0]  PERIPH_SEL,
	input wire logic [7:0]  CELL_A_OUT,
	input wire logic        STANDBY
);
	import plddec_pkg::*;

	logic [7:0] mask_a_r;
	logic       wr_a;

	default clocking cb @(posedge CLK); endclocking
	default disable iff (!NRST);

	// ****************************************************
	// shadow of the group a mask, fed by host writes
	// ****************************************************
	assign wr_a = CONFIG_BLOCK_SEL && ADDR[7:0] == OFS_MASK_A;
	always_ff @(posedge CLK) begin
		if (!NRST) begin
			mask_a_r <= 8'h00;
		end else if ($rose(BUS_CNTL_N[0]) && wr_a) begin
			mask_a_r <= DATA_IN;
		end
	end

	AST_PRIO_LEVEL1: assert property ((SRAM_SEL || CONFIG_BLOCK_SEL || PERIPH_SEL != 2'h0)
		|-> PRIMARY_SECTOR_SEL == 8'h00 && SECONDARY_SECTOR_SEL == 4'h0)
		else $error("flash select active beside sram or io select");
	AST_PRIO_LEVEL2: assert property (SECONDARY_SECTOR_SEL != 4'h0 |-> PRIMARY_SECTOR_SEL == 8'h00)
		else $error("primary select active beside secondary select");
	AST_CFG_DECODE: assert property (CONFIG_BLOCK_SEL == (WIDE_ADDR_MODE ?
		(&ADDR[19:12]) : (&ADDR[15:8])))
		else $error("config block select does not follow address");
	AST_ID0_READ: assert property (!BUS_CNTL_N[1] && CONFIG_BLOCK_SEL && ADDR[7:0] == OFS_ID0
		|=> DATA_OE && DATA_OUT == ID0_VALUE)
		else $error("first id register read wrong");
	AST_ID1_READ: assert property (!BUS_CNTL_N[1] && CONFIG_BLOCK_SEL && ADDR[7:0] == OFS_ID1
		|=> DATA_OE && DATA_OUT == ID1_VALUE)
		else $error("second id register read wrong");
	AST_READ_IDLE: assert property ((BUS_CNTL_N[1] || !CONFIG_BLOCK_SEL)
		|=> !DATA_OE && DATA_OUT == 8'h00)
		else $error("read data driven without a read");
	AST_CELL_LOAD: assert property ($rose(BUS_CNTL_N[0]) && CONFIG_BLOCK_SEL
		&& ADDR[7:0] == OFS_CELL_A
		|=> CELL_A_OUT == (($past(DATA_IN) & ~mask_a_r) | ($past(CELL_A_OUT) & mask_a_r)))
		else $error("host load of cell group a wrong");
	AST_STBY_WAKE: assert property (!WIDE_ADDR_MODE && ADDR[15:0] != $past(ADDR[15:0])
		|=> !STANDBY)
		else $error("standby held across an address change");
	AST_STBY_ENTER: assert property ($rose(STANDBY) |-> $past(ADDR, 1) == $past(ADDR, 7))
		else $error("standby entered while address moving");
endmodule

bind plddec_top plddec_top_props u_props (
	.CLK(CLK), .NRST(NRST), .ADDR(ADDR), .WIDE_ADDR_MODE(WIDE_ADDR_MODE),
	.BUS_CNTL_N(BUS_CNTL_N), .DATA_IN(DATA_IN), .DATA_OUT(DATA_OUT), .DATA_OE(DATA_OE),
	.PRIMARY_SECTOR_SEL(PRIMARY_SECTOR_SEL), .SECONDARY_SECTOR_SEL(SECONDARY_SECTOR_SEL),
	.SRAM_SEL(SRAM_SEL), .CONFIG_BLOCK_SEL(CONFIG_BLOCK_SEL), .PERIPH_SEL(PERIPH_SEL),
	.CELL_A_OUT(CELL_A_OUT), .STANDBY(STANDBY));

// ---- bench/plddec_host_model.sv ----
// host bus model: drives address, strobes and write data, collects read answers
`timescale 1ns/1ps
module plddec_host_model (
	input  wire logic       clk,
	input  wire logic [7:0] data_out,
	input  wire logic       data_oe,
	output logic [19:0]     addr,
	output logic [2:0]      cntl_n,
	output logic [7:0]      wdata
);
	initial begin
		addr   = 20'h00000;
		cntl_n = 3'h7;
		wdata  = 8'h00;
	end

	task automatic put_addr(input logic [19:0] a);
		@(posedge clk);
		addr <= a;
	endtask

	// control-blocking bits stay clear: the host controls feed live equations
	task automatic wr(input logic [19:0] a, input logic [7:0] d);
		@(posedge clk);
		addr      <= a;
		wdata     <= d;
		cntl_n[0] <= 1'b0;
		@(posedge clk);
		cntl_n[0] <= 1'b1;
		@(posedge clk);
		wdata <= ~d;
	endtask

	task automatic rd(input logic [19:0] a, output logic [7:0] d, output logic oe);
		@(posedge clk);
		addr      <= a;
		cntl_n[1] <= 1'b0;
		@(posedge clk);
		@(posedge clk);
		#1;
		d  = data_out;
		oe = data_oe;
		@(posedge clk);
		cntl_n[1] <= 1'b1;
	endtask
endmodule

// ---- bench/plddec_top_tb.sv ----
// self-checking bench of the programmable logic section
`timescale 1ns/1ps
module plddec_top_tb;
	import plddec_pkg::*;

	function automatic plddec_dec_tab_t dec_tab();
		plddec_dec_tab_t t;
		t = '0;
		t[DT_PRI][15]     = 1'b1;
		t[DT_SEC][15:14]  = 2'h3;
		t[DT_SRAM][15:13] = 3'h7;
		t[DT_CFG][15:8]   = 8'hFF;
		t[DT_JTAG][BP_PF] = 1'b1;
		t[DT_PERIPH][BP_PAGE] = 1'b1;
		return t;
	endfunction
	function automatic plddec_gen_tab_t gen_tab();
		plddec_gen_tab_t t;
		t = '0;
		t[GT_ECS][BP_PD] = 1'b1;
		return t;
	endfunction
	localparam plddec_dec_tab_t      DTAB = dec_tab();
	localparam plddec_gen_tab_t      GTAB = gen_tab();
	localparam logic [DEC_TERMS-1:0] DUSE = DEC_TERMS'((64'h1 << DT_PRI) | (64'h1 << DT_SEC)
		| (64'h1 << DT_SRAM) | (64'h1 << DT_CFG) | (64'h1 << DT_JTAG)
		| (64'h1 << DT_PERIPH));
	localparam logic [GEN_TERMS-1:0] GUSE = {{(GEN_TERMS-1){1'b0}}, 1'b1} << GT_ECS;

	logic        clk, nrst, wide, power_down_input, rdy;
	logic [7:0]  pa, pb, pc, pf, dout, cell_a, cell_b, page, pri;
	logic [3:0]  pd, sec;
	logic [19:0] addr;
	logic [2:0]  cntl_n, ecs;
	logic [7:0]  wdata;
	logic [1:0]  per;
	logic        oe, sram, cfg, jtag, standby;
	logic [15:0] sel_v;
	int          fails, comparisons;
	logic [19:0] da [7] = '{20'h04000, 20'h08000, 20'h0C000, 20'h0E000, 20'h0FF00,
		20'h80000, 20'h08000};
	logic        dw [7] = '{1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 1'b1};
	logic [15:0] de [7] = '{16'h0000, 16'h0100, 16'h0010, 16'h0008, 16'h000C,
		16'h0100, 16'h0000};

	assign sel_v = {pri, sec, sram, cfg, jtag, ecs[0]};

	plddec_host_model u_host (.clk(clk), .data_out(dout), .data_oe(oe), .addr(addr),
		.cntl_n(cntl_n), .wdata(wdata));

	plddec_top #(.DEC_TRUE(DTAB), .DEC_USED(DUSE), .GEN_TRUE(GTAB), .GEN_USED(GUSE)) u_dut (
		.CLK(clk), .NRST(nrst), .ADDR(addr), .WIDE_ADDR_MODE(wide), .BUS_CNTL_N(cntl_n),
		.DATA_IN(wdata), .DATA_OUT(dout), .DATA_OE(oe), .POWER_DOWN_IN(power_down_input),
		.PORT_A_IN(pa), .PORT_B_IN(pb), .PORT_C_IN(pc), .PORT_D_IN(pd), .PORT_F_IN(pf),
		.SEC_FLASH_READY(rdy), .PRIMARY_SECTOR_SEL(pri), .SECONDARY_SECTOR_SEL(sec),
		.SRAM_SEL(sram), .CONFIG_BLOCK_SEL(cfg), .JTAG_PORT_SEL(jtag), .PERIPH_SEL(per),
		.EXT_CHIP_SEL(ecs), .CELL_A_OUT(cell_a), .CELL_B_OUT(cell_b), .PAGE_OUT(page),
		.STANDBY(standby));

	// ****************************************************
	// compare, read and closing tasks
	// ****************************************************
	task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
		comparisons++;
		if (got !== exp) begin
			fails++;
			$display("[FAIL] %0t byte got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic chk16(input logic [15:0] got, input logic [15:0] exp);
		comparisons++;
		if (got !== exp) begin
			fails++;
			$display("[FAIL] %0t selects got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic rdc(input logic [19:0] a, input logic [7:0] e);
		logic [7:0] d;
		logic       o;
		u_host.rd(a, d, o);
		chk8(d, e);
		chk8({7'h00, o}, 8'h01);
	endtask
	task automatic end_of_test();
		if (fails == 0 && comparisons > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask

	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	initial begin
		#20000;
		fails++;
		end_of_test();
	end
	initial begin
		{nrst, wide, power_down_input, rdy, pa, pb, pc, pd, pf} = '0;
		repeat (8) @(posedge clk);
		nrst <= 1'b1;
		rdc(20'h0FFF0, ID0_VALUE);
		rdc(20'h0FFF1, ID1_VALUE);
		u_host.wr(20'h0FFF0, 8'h00);
		rdc(20'h0FFF0, ID0_VALUE);
		rdc(20'h0FF55, 8'h00);
		u_host.wr(20'h0FF20, 8'h3C);
		#1 chk8(cell_a, 8'h3C);
		u_host.wr(20'h0FF22, 8'h0F);
		u_host.wr(20'h0FF20, 8'hC3);
		#1 chk8(cell_a, 8'hCC);
		rdc(20'h0FF20, 8'hCC);
		u_host.wr(20'h01021, 8'h77);
		#1 chk8(cell_b, 8'h00);
		u_host.wr(20'h0FF21, 8'h99);
		#1 chk8(cell_b, 8'h99);
		@(posedge clk) pa <= 8'hA6;
		rdc(20'h0FF18, 8'hA6);
		for (int i = 0; i < 7; i++) begin
			@(posedge clk) wide <= dw[i];
			u_host.put_addr(da[i]);
			#1 chk16(sel_v, de[i]);
		end
		@(posedge clk);
		wide <= 1'b0;
		pf   <= 8'h01;
		pd   <= 4'h1;
		u_host.put_addr(20'h04000);
		#1 chk16(sel_v, 16'h0003);
		repeat (10) @(posedge clk);
		#1 chk8({7'h00, standby}, 8'h01);
		@(posedge clk) pc <= 8'h55;
		@(posedge clk);
		#1 chk8({7'h00, standby}, 8'h00);
		u_host.wr(20'h0FFB0, 8'h08);
		repeat (12) @(posedge clk);
		#1 chk8({7'h00, standby}, 8'h00);
		u_host.wr(20'h0FFE0, 8'h01);
		#1 chk8(page, 8'h01);
		chk8({6'h00, per}, 8'h01);
		rdc(20'h0FFE0, 8'h01);
		u_host.put_addr(20'h08000);
		#1 chk16(sel_v, 16'h0003);
		end_of_test();
	end
endmodule
